// ==== hw/rib_params.svh ====
// Constants of the reset-initialization register bank.
`ifndef RIB_PARAMS_SVH
`define RIB_PARAMS_SVH
`define RIB_AW            5
`define RIB_A_IP1H        5'h00
`define RIB_A_IP1L        5'h01
`define RIB_A_BANK        5'h02
`define RIB_A_IP2H        5'h03
`define RIB_A_IP2L        5'h04
`define RIB_A_ALU         5'h05
`define RIB_A_T0H         5'h06
`define RIB_A_T0L         5'h07
`define RIB_A_T0CTL       5'h08
`define RIB_A_OSC         5'h09
`define RIB_A_LVD         5'h0a
`define RIB_A_WDOG        5'h0b
`define RIB_A_RCAUSE      5'h0c
`define RIB_A_T1H         5'h0d
`define RIB_A_T1L         5'h0e
`define RIB_A_T1CTL       5'h0f
`define RIB_A_T2          5'h10
`define RIB_A_T2PER       5'h11
`define RIB_A_T2CTL       5'h12
`define RIB_A_SBUF        5'h13
`define RIB_A_SADD        5'h14
`define RIB_A_SSTAT       5'h15
`define RIB_A_SCON1       5'h16
`define RIB_A_SCON2       5'h17
`define RIB_A_PA_IN       5'h18
`define RIB_A_PA_LAT      5'h19
`define RIB_A_PA_DIR      5'h1a
`define RIB_A_IRQST       5'h1b
`define RIB_A_IRQMSK      5'h1c
`define RIB_A_SP          5'h1d
`define RIB_A_TOS_LO      5'h1e
`define RIB_A_TOS_HI      5'h1f
`define RIB_R_T0CTL       8'hff
`define RIB_R_LVD         8'h05
`define RIB_R_OSC         8'h40
`define RIB_R_RCAUSE      8'h1c
`define RIB_R_T2PER       8'hff
`define RIB_R_PA_DIR      8'hff
`define RIB_M_OSC_WR      8'h73
`define RIB_M_LVD_WR      8'hbf
`define RIB_M_T2CTL       8'h7f
`define RIB_M_NIB         8'h0f
`define RIB_M_ALU         8'h1f
`define RIB_M_WDOG        8'h01
`define RIB_M_PA_HI       8'hc0
`define RIB_M_T1CTL_KEEP  8'hbf
`define RIB_OSC_PA_LO     3'h4
`define RIB_OSC_PA_HI     3'h5
`define RIB_VEC_HIGH      21'h000008
`define RIB_VEC_LOW       21'h000018
`define RIB_PC_STEP       21'h000002
`define RIB_SP_STEP       5'h01
`define RIB_SP_OVF_BIT    7
`define RIB_IRQ_WAKE      0
`define RIB_IRQ_RST2      1
`define RIB_IRQ_POR       2
`define RIB_IRQ_N         3
`endif

// ==== hw/rib_pkg.sv ====
// Types of the reset-initialization register bank.
package rib_pkg;
   typedef enum logic [1:0] {
      RIB_RUN   = 2'b00,
      RIB_SLEEP = 2'b01
   } rib_pwr_e;
endpackage

// ==== hw/rib_bank.sv ====
// Reset-initialization register bank with wake-up vectoring.
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "rib_params.svh"
module rib_bank (
   // Clock and power-on reset.
   input  wire logic        clk,
   input  wire logic        rst,
   // Second-class reset and wake-up requests, core clock domain.
   input  wire logic        warm_reset,
   input  wire logic        sleep_enter,
   input  wire logic        wake_watchdog,
   input  wire logic        wake_irq,
   input  wire logic        wake_irq_high,
   input  wire logic        high_priority_global_irq_enable,
   input  wire logic        low_priority_global_irq_enable,
   input  wire logic [20:0] program_counter_in,
   // Oscillator mode strap and port A pins.
   input  wire logic [2:0]  osc_mode,
   input  wire logic [7:0]  port_a_pins,
   // Register port.
   input  wire logic [4:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Core results.
   output logic      [20:0] program_counter,
   output logic      [20:0] top_of_stack,
   output logic      [7:0]  return_stack_pointer,
   output logic      [7:0]  peripheral_irq_flag_regs,
   output logic      [7:0]  port_a_latch_out,
   output logic      [7:0]  port_a_direction_out,
   output logic             asleep,
   output logic             irq
);
   // Register storage, flat array by address.
   logic [7:0]  regs_r [0:26];
   logic [7:0]  regs_nxt [0:26];
   logic [7:0]  pa_sync1_r;
   logic [7:0]  pa_sync2_r;
   logic [2:0]  osc_r;
   logic [20:0] pc_r;
   logic [20:0] tos_r;
   logic [7:0]  sp_r;
   logic [7:0]  pif_r;
   logic [2:0]  irq_st_r;
   logic [2:0]  irq_msk_r;
   logic [7:0]  rdata_r;
   logic        irq_r;
   logic [2:0]  osc_sync1_r;
   rib_pkg::rib_pwr_e pwr_r;
   logic        por_seen_r;

   wire         any_gie   = high_priority_global_irq_enable | low_priority_global_irq_enable;
   wire         irq_wake  = (pwr_r == rib_pkg::RIB_SLEEP) & wake_irq;
   wire         wdog_wake = (pwr_r == rib_pkg::RIB_SLEEP) & wake_watchdog & ~wake_irq;
   wire         vector_go = irq_wake & any_gie;
   wire         pa_hi_en  = (osc_r == `RIB_OSC_PA_LO) | (osc_r == `RIB_OSC_PA_HI);
   wire [7:0]   pa_mask   = pa_hi_en ? 8'hff : ~`RIB_M_PA_HI;
   wire         wr_msk    = reg_wr & (reg_addr == `RIB_A_IRQMSK);
   wire         rd_st     = reg_rd & (reg_addr == `RIB_A_IRQST);
   wire         wr_sp     = reg_wr & (reg_addr == `RIB_A_SP);
   wire [2:0]   irq_ev    = {por_seen_r, warm_reset, irq_wake | wdog_wake};
   // Status and mask as they will be after this edge, so the interrupt line tracks them without lag.
   wire [2:0]   st_nxt    = (rd_st ? 3'h0 : irq_st_r) | irq_ev;
   wire [2:0]   msk_nxt   = wr_msk ? reg_wdata[2:0] : irq_msk_r;
   wire [20:0]  vec_addr  = wake_irq_high ? `RIB_VEC_HIGH : `RIB_VEC_LOW;

   // Write path: masks for read-only and unimplemented bits.
   always_comb begin
      for (int i = 0; i < 27; i++) begin
         regs_nxt[i] = regs_r[i];
      end
      if (reg_wr && reg_addr <= `RIB_A_PA_DIR) begin
         unique case (reg_addr)
            `RIB_A_IP1H, `RIB_A_BANK, `RIB_A_IP2H: regs_nxt[reg_addr] = reg_wdata & `RIB_M_NIB;
            `RIB_A_ALU: regs_nxt[reg_addr] = reg_wdata & `RIB_M_ALU;
            `RIB_A_WDOG: regs_nxt[reg_addr] = reg_wdata & `RIB_M_WDOG;
            `RIB_A_OSC: regs_nxt[reg_addr] = (regs_r[reg_addr] & ~`RIB_M_OSC_WR) | (reg_wdata & `RIB_M_OSC_WR);
            `RIB_A_LVD: regs_nxt[reg_addr] = (regs_r[reg_addr] & ~`RIB_M_LVD_WR) | (reg_wdata & `RIB_M_LVD_WR);
            `RIB_A_T2CTL: regs_nxt[reg_addr] = reg_wdata & `RIB_M_T2CTL;
            default: regs_nxt[reg_addr] = reg_wdata;
         endcase
      end
      // Upper port bits vanish as soon as the oscillator mode takes the pins back.
      regs_nxt[`RIB_A_PA_LAT] = regs_nxt[`RIB_A_PA_LAT] & pa_mask;
      regs_nxt[`RIB_A_PA_DIR] = regs_nxt[`RIB_A_PA_DIR] & pa_mask;
      regs_nxt[`RIB_A_PA_IN]  = pa_sync2_r & pa_mask;
   end

   // Power-on values; wake-ups leave bits unchanged.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 27; i++) begin
            regs_r[i] <= 8'h00;
         end
         regs_r[`RIB_A_T0CTL]  <= `RIB_R_T0CTL;
         regs_r[`RIB_A_LVD]    <= `RIB_R_LVD;
         regs_r[`RIB_A_OSC]    <= `RIB_R_OSC;
         regs_r[`RIB_A_RCAUSE] <= `RIB_R_RCAUSE;
         regs_r[`RIB_A_T2PER]  <= `RIB_R_T2PER;
         regs_r[`RIB_A_PA_DIR] <= `RIB_R_PA_DIR & ~`RIB_M_PA_HI;
      end else if (warm_reset) begin
         // Second-class values: timer 2 period, timer 1 control apart from bit 6, T0L, timer 1 counters and data keep; T0H and T2 clear.
         for (int i = 0; i < 27; i++) begin
            regs_r[i] <= regs_r[i];
         end
         regs_r[`RIB_A_IP1H]   <= 8'h00;
         regs_r[`RIB_A_BANK]   <= 8'h00;
         regs_r[`RIB_A_IP2H]   <= 8'h00;
         regs_r[`RIB_A_T0H]    <= 8'h00;
         regs_r[`RIB_A_T0CTL]  <= `RIB_R_T0CTL;
         regs_r[`RIB_A_OSC]    <= `RIB_R_OSC;
         regs_r[`RIB_A_LVD]    <= `RIB_R_LVD;
         regs_r[`RIB_A_WDOG]   <= 8'h00;
         regs_r[`RIB_A_T1CTL]  <= regs_r[`RIB_A_T1CTL] & `RIB_M_T1CTL_KEEP;
         regs_r[`RIB_A_T2]     <= 8'h00;
         regs_r[`RIB_A_T2CTL]  <= 8'h00;
         regs_r[`RIB_A_SADD]   <= 8'h00;
         regs_r[`RIB_A_SSTAT]  <= 8'h00;
         regs_r[`RIB_A_SCON1]  <= 8'h00;
         regs_r[`RIB_A_SCON2]  <= 8'h00;
         regs_r[`RIB_A_PA_DIR] <= `RIB_R_PA_DIR & pa_mask;
         regs_r[`RIB_A_PA_LAT] <= regs_r[`RIB_A_PA_LAT] & pa_mask;
      end else begin
         for (int i = 0; i < 27; i++) begin
            regs_r[i] <= regs_nxt[i];
         end
      end
   end

   // Port pins pass two flip-flops; oscillator mode passes two flip-flops as well, every cycle.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pa_sync1_r <= 8'h00;
         pa_sync2_r <= 8'h00;
         osc_sync1_r <= 3'h0;
         osc_r      <= 3'h0;
         por_seen_r <= 1'b1;
      end else begin
         pa_sync1_r <= port_a_pins;
         pa_sync2_r <= pa_sync1_r;
         osc_sync1_r <= osc_mode;
         osc_r      <= osc_sync1_r;
         por_seen_r <= 1'b0;
      end
   end

   // Power state, program counter and return stack.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwr_r <= rib_pkg::RIB_RUN;
         pc_r  <= 21'h000000;
         tos_r <= 21'h000000;
         sp_r  <= 8'h00;
      end else if (warm_reset) begin
         pwr_r <= rib_pkg::RIB_RUN;
         pc_r  <= 21'h000000;
         tos_r <= 21'h000000;
         sp_r  <= {sp_r[7:6], 6'h00};
      end else if (vector_go) begin
         pwr_r <= rib_pkg::RIB_RUN;
         pc_r  <= vec_addr;
         tos_r <= program_counter_in;
         sp_r  <= {sp_r[7:5], sp_r[4:0] + `RIB_SP_STEP};
      end else if (irq_wake | wdog_wake) begin
         pwr_r <= rib_pkg::RIB_RUN;
         pc_r  <= program_counter_in + `RIB_PC_STEP;
      end else begin
         if (sleep_enter) begin
            pwr_r <= rib_pkg::RIB_SLEEP;
         end
         pc_r <= program_counter_in;
         if (wr_sp) begin
            sp_r <= {reg_wdata[7:6], 1'b0, reg_wdata[4:0]};
         end
      end
   end

   // Wake-cause flags, interrupt status and read port.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pif_r     <= 8'h00;
         irq_st_r  <= 3'h0;
         irq_msk_r <= 3'h0;
         rdata_r   <= 8'h00;
         irq_r     <= 1'b0;
      end else begin
         if (irq_wake) begin
            pif_r <= pif_r | 8'h01;
         end
         irq_st_r  <= st_nxt;
         irq_msk_r <= msk_nxt;
         irq_r     <= |(st_nxt & msk_nxt);
         rdata_r <= 8'h00;
         if (reg_rd) begin
            if (reg_addr <= `RIB_A_PA_DIR) begin
               rdata_r <= regs_r[reg_addr];
            end else if (reg_addr == `RIB_A_IRQST) begin
               rdata_r <= {5'h00, irq_st_r};
            end else if (reg_addr == `RIB_A_IRQMSK) begin
               rdata_r <= {5'h00, irq_msk_r};
            end else if (reg_addr == `RIB_A_SP) begin
               rdata_r <= sp_r;
            end else if (reg_addr == `RIB_A_TOS_LO) begin
               rdata_r <= tos_r[7:0];
            end else begin
               rdata_r <= tos_r[15:8];
            end
         end
      end
   end

   assign reg_rdata                = rdata_r;
   assign program_counter          = pc_r;
   assign top_of_stack             = tos_r;
   assign return_stack_pointer     = sp_r;
   assign peripheral_irq_flag_regs = pif_r;
   assign port_a_latch_out         = regs_r[`RIB_A_PA_LAT];
   assign port_a_direction_out     = regs_r[`RIB_A_PA_DIR];
   // The sleep code is the only state with bit 0 set, so the flag comes straight from the state flop.
   assign asleep                   = pwr_r[0];
   assign irq                      = irq_r;
endmodule

// ==== bench/rib_bank_chk.sv ====
// Concurrent checks on the register bank outputs.
`timescale 1ns/100ps
`include "rib_params.svh"
module rib_bank_chk (
   // Clock and resets.
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        warm_reset,
   // Wake-up inputs and oscillator mode.
   input wire logic        wake_irq,
   input wire logic        wake_irq_high,
   input wire logic        high_priority_global_irq_enable,
   input wire logic        low_priority_global_irq_enable,
   input wire logic [20:0] program_counter_in,
   input wire logic [2:0]  osc_mode,
   // Results.
   input wire logic [20:0] program_counter,
   input wire logic [20:0] top_of_stack,
   input wire logic [7:0]  return_stack_pointer,
   input wire logic [7:0]  peripheral_irq_flag_regs,
   input wire logic [7:0]  port_a_latch_out,
   input wire logic [7:0]  port_a_direction_out,
   input wire logic        asleep
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_wake;
      asleep && wake_irq && !warm_reset;
   endsequence
   sequence s_vec;
      s_wake ##0 (high_priority_global_irq_enable || low_priority_global_irq_enable);
   endsequence
   a_wake_flag: assert property (s_wake |=> peripheral_irq_flag_regs[0])
      else $error("wake flag not set");
   a_wake_vector: assert property (s_vec |=>
      program_counter == ($past(wake_irq_high) ? `RIB_VEC_HIGH : `RIB_VEC_LOW)) else $error("bad vector");
   a_stack_copy: assert property (s_vec |=> top_of_stack == $past(program_counter_in))
      else $error("stack top not loaded");
   a_stack_step: assert property (s_vec |=>
      return_stack_pointer[4:0] == $past(return_stack_pointer[4:0]) + 5'h01) else $error("pointer not advanced");
   a_pin_hidden: assert property ((osc_mode != `RIB_OSC_PA_LO && osc_mode != `RIB_OSC_PA_HI) [*4] |->
      port_a_latch_out[7:6] == 2'b00 && port_a_direction_out[7:6] == 2'b00) else $error("hidden pins visible");
   a_warm_ptr: assert property (warm_reset |=> return_stack_pointer[4:0] == 5'h00)
      else $error("pointer kept on warm reset");
   a_sleep_exit: assert property (s_wake |=> !asleep) else $error("still asleep");
endmodule
bind rib_bank rib_bank_chk rib_bank_chk_i (.clk(clk), .rst(rst), .warm_reset(warm_reset), .wake_irq(wake_irq),
   .wake_irq_high(wake_irq_high), .high_priority_global_irq_enable(high_priority_global_irq_enable),
   .low_priority_global_irq_enable(low_priority_global_irq_enable), .program_counter_in(program_counter_in),
   .osc_mode(osc_mode), .program_counter(program_counter), .top_of_stack(top_of_stack),
   .return_stack_pointer(return_stack_pointer), .peripheral_irq_flag_regs(peripheral_irq_flag_regs),
   .port_a_latch_out(port_a_latch_out), .port_a_direction_out(port_a_direction_out), .asleep(asleep));

// ==== bench/testbench.sv ====
// Self-checking bench for the register bank.
`timescale 1ns/100ps
`include "rib_params.svh"
module testbench;
   logic        clk = 0, rst = 1, warm_reset = 0, sleep_enter = 0, wake_wd = 0, wake_irq = 0;
   logic        wr = 0, rd = 0, hi = 0, gie_h = 0, gie_l = 0, asleep, irq, v;
   logic [20:0] pc_in = 0, pc, tos, etos = 0;
   logic [7:0]  wdata = 0, rdata, sp, pif, lat, dir, pins = 0, k;
   logic [4:0]  addr = 0, esp = 0;
   logic [2:0]  mode = 0;
   logic [11:0] md = {3'h3, 3'h5, 3'h4, 3'h0};
   logic [23:0] kp = 24'h0a60b2;
   logic [7:0]  m [0:26];
   logic [7:0]  wm [0:23] = '{8'h0f, 8'hff, 8'h0f, 8'h0f, 8'hff, 8'h1f, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h01,
                              8'h00, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'h00, 8'hff, 8'hff};
   int          err_total = 0, compares = 0, r;
   always #5 clk = ~clk;
   rib_bank rib_bank_i (.clk(clk), .rst(rst), .warm_reset(warm_reset), .sleep_enter(sleep_enter),
      .wake_watchdog(wake_wd), .wake_irq(wake_irq), .wake_irq_high(hi), .high_priority_global_irq_enable(gie_h),
      .low_priority_global_irq_enable(gie_l), .program_counter_in(pc_in), .osc_mode(mode), .port_a_pins(pins),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .program_counter(pc),
      .top_of_stack(tos), .return_stack_pointer(sp), .peripheral_irq_flag_regs(pif), .port_a_latch_out(lat),
      .port_a_direction_out(dir), .asleep(asleep), .irq(irq));
   function automatic logic [7:0] rv(input int a);
      case (a)
         8, 17: rv = 8'hff;
         9: rv = 8'h40;
         10: rv = 8'h05;
         12: rv = 8'h1c;
         26: rv = 8'h3f;
         default: rv = 8'h00;
      endcase
   endfunction
   task automatic summarize();
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic cmp_core(input logic [20:0] g, input logic [20:0] e);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %0t core got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmp_reg(input logic [4:0] a, input logic [7:0] e, input logic [7:0] c);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      compares++;
      if ((rdata & c) !== (e & c)) begin
         err_total++;
         $display("mismatch %0t reg %h got %h exp %h", $time, a, rdata, e);
      end
   endtask
   task automatic wrr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Bits left undefined by each reset class are masked out of the compare.
   task automatic scan(input logic warm);
      for (int a = 0; a < 27; a++) begin
         k = (a == 9) ? 8'hf7 : (a == 10) ? 8'hbf : (a == 18) ? 8'h7f : (a == 24) ? 8'h00 : 8'hff;
         if (a == 12) k = warm ? 8'h80 : 8'h9d;
         cmp_reg(a[4:0], m[a], k);
      end
   endtask
   initial begin
      #100000;
      err_total++;
      summarize();
   end
   initial begin
      r = $urandom(36053);
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 27; a++) m[a] = rv(a);
      scan(1'b0);
      cmp_reg(5'h1b, 8'h04, 8'h04);
      for (int a = 0; a < 24; a++) begin
         r = $urandom;
         if (wm[a] != 8'h00) wrr(a[4:0], r[7:0]);
         if (wm[a] != 8'h00) m[a] = r[7:0] & wm[a];
      end
      scan(1'b0);
      @(posedge clk);
      warm_reset <= 1'b1;
      @(posedge clk);
      warm_reset <= 1'b0;
      for (int a = 0; a < 24; a++) if (!kp[a]) m[a] = rv(a);
      scan(1'b1);
      cmp_reg(5'h1b, 8'h02, 8'h02);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         mode <= md[3*i +: 3];
         pins <= 8'($urandom);
         repeat (4) @(posedge clk);
         wrr(5'h19, 8'hff);
         wrr(5'h1a, 8'hff);
         k = (md[3*i +: 3] inside {3'h4, 3'h5}) ? 8'hff : 8'h3f;
         cmp_reg(5'h18, pins & k, 8'hff);
         cmp_reg(5'h19, k, 8'hff);
         cmp_reg(5'h1a, k, 8'hff);
         cmp_core({13'h0, lat}, {13'h0, k});
         cmp_core({13'h0, dir}, {13'h0, k});
      end
      wrr(5'h1d, 8'hc3);
      esp = 5'h03;
      cmp_reg(5'h1d, 8'hc3, 8'hff);
      for (int i = 0; i < 5; i++) begin
         r = $urandom;
         wrr(5'h1c, (i == 3) ? 8'h00 : 8'h01);
         @(posedge clk);
         sleep_enter <= 1'b1;
         pc_in <= r[20:0];
         hi <= i[0];
         gie_h <= i[1] & i[0];
         gie_l <= i[1] & ~i[0];
         @(posedge clk);
         sleep_enter <= 1'b0;
         @(posedge clk);
         wake_irq <= (i < 4);
         wake_wd <= (i == 4);
         #1;
         cmp_core({20'h0, asleep}, 21'h1);
         @(posedge clk);
         wake_irq <= 1'b0;
         wake_wd <= 1'b0;
         #1;
         v = i[1] && i < 4;
         cmp_core(pc, v ? (i[0] ? `RIB_VEC_HIGH : `RIB_VEC_LOW) : r[20:0] + 21'h2);
         if (v) etos = r[20:0];
         if (v) esp = esp + 5'h01;
         cmp_core(tos, etos);
         cmp_core({16'h0, sp[4:0]}, {16'h0, esp});
         cmp_core({13'h0, pif}, 21'h1);
         cmp_core({20'h0, irq}, {20'h0, i != 3});
         cmp_core({20'h0, asleep}, 21'h0);
         cmp_reg(5'h1b, 8'h01, 8'hff);
         @(posedge clk);
         #1;
         cmp_core({20'h0, irq}, 21'h0);
      end
      cmp_reg(5'h1e, etos[7:0], 8'hff);
      cmp_reg(5'h1f, etos[15:8], 8'hff);
      summarize();
   end
endmodule
